// ==== test/sbtl_sec_agent.sv ====
// Behavioural secondary bus agent: claiming target and locking initiator
`timescale 1ns/1ps
module sbtl_sec_agent (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic [3:0] i_claim_dly,
    input wire logic [3:0] i_stop_dly,
    input wire logic i_lock_req,
    output logic o_claim_n,
    output logic o_claim_oe,
    output logic o_stop_n,
    output logic o_stop_oe,
    output logic o_lock_n,
    output logic o_lock_oe
);
    logic [3:0] cnt_r;
    logic [1:0] lock_r;
    logic [3:0] stop_at;
    assign stop_at = i_claim_dly + i_stop_dly;
    // Cycles since frame; zero delay means no target claims
    always_ff @(posedge i_clk) begin
        if (!i_rstn) cnt_r <= 4'h0;
        else if (i_start && i_claim_dly != 4'h0) cnt_r <= 4'h1;
        else if (cnt_r != 4'h0 && cnt_r <= stop_at) cnt_r <= cnt_r + 4'h1;
        else cnt_r <= 4'h0;
    end
    // Claim low from the claim cycle, parked high one cycle before release
    assign o_claim_oe = cnt_r != 4'h0 && cnt_r >= i_claim_dly;
    assign o_claim_n = !(o_claim_oe && cnt_r <= stop_at);
    assign o_stop_oe = o_claim_oe;
    assign o_stop_n = cnt_r != stop_at;
    // Lock as initiator: driven while asked, then one parked cycle
    always_ff @(posedge i_clk) begin
        if (!i_rstn) lock_r <= 2'h0;
        else if (i_lock_req) lock_r <= 2'h1;
        else if (lock_r == 2'h1) lock_r <= 2'h2;
        else lock_r <= 2'h0;
    end
    assign o_lock_oe = lock_r != 2'h0;
    assign o_lock_n = lock_r != 2'h1;
endmodule

// ==== test/secondary_bus_termination_lock_bench.sv ====
// Self-checking bench for the secondary bus termination and lock block
`timescale 1ns/1ps
module secondary_bus_termination_lock_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic frame = 1'b0;
    logic locked = 1'b0;
    logic last = 1'b0;
    logic lock_done = 1'b0;
    logic tgt_claim = 1'b0;
    logic tgt_stop = 1'b0;
    logic tgt_end = 1'b0;
    logic lock_req = 1'b0;
    logic [3:0] claim_dly = 4'h0;
    logic [3:0] stop_dly = 4'h0;
    logic dco, dcoe, dso, dsoe, dlo, dloe, pco, pcoe, pso, psoe, plo, ploe;
    logic busy, claimed, abort, stopped, drop;
    logic claim_w, stop_w, lock_w;
    int errors = 0;
    int cmp_count = 0;
    int drop_cnt = 0;
    int up_oe = 0;
    // Released lines float to the pull-up level
    assign claim_w = (~dcoe | dco) & (~pcoe | pco);
    assign stop_w = (~dsoe | dso) & (~psoe | pso);
    assign lock_w = (~dloe | dlo) & (~ploe | plo);
    always #5 clk = ~clk;
    sbtl_top dut_u (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_CE(ce), .I_MST_FRAME_START(frame),
        .I_MST_LOCKED(locked), .I_MST_LAST(last), .I_LOCK_DONE(lock_done),
        .I_TGT_CLAIM(tgt_claim), .I_TGT_STOP(tgt_stop), .I_TGT_END(tgt_end),
        .I_SEC_TARGET_CLAIM_N_I(claim_w), .I_SEC_STOP_N_I(stop_w), .I_SEC_LOCK_N_I(lock_w),
        .O_SEC_TARGET_CLAIM_N_O(dco), .O_SEC_TARGET_CLAIM_N_OE(dcoe), .O_SEC_STOP_N_O(dso),
        .O_SEC_STOP_N_OE(dsoe), .O_SEC_LOCK_N_O(dlo), .O_SEC_LOCK_N_OE(dloe),
        .O_MST_BUSY(busy), .O_MST_CLAIMED(claimed), .O_MST_ABORT(abort),
        .O_MST_STOPPED(stopped), .O_UP_LOCK_DROP(drop));
    sbtl_sec_agent agent_u (.i_clk(clk), .i_rstn(rstn), .i_start(frame),
        .i_claim_dly(claim_dly), .i_stop_dly(stop_dly), .i_lock_req(lock_req),
        .o_claim_n(pco), .o_claim_oe(pcoe), .o_stop_n(pso), .o_stop_oe(psoe),
        .o_lock_n(plo), .o_lock_oe(ploe));
    // Upstream lock evidence, counted every cycle
    always @(posedge clk) begin
        if (drop === 1'b1) drop_cnt++;
        if (dloe !== 1'b0) up_oe++;
    end
    task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Frame start; returns settled in cycle 1
    task automatic start_mst(input logic [3:0] cd, input logic [3:0] sd, input logic lk);
        @(posedge clk);
        claim_dly <= cd;
        stop_dly <= sd;
        frame <= 1'b1;
        locked <= lk;
        @(posedge clk);
        frame <= 1'b0;
        locked <= 1'b0;
        #1;
    endtask
    task automatic t_claim_stop;
        start_mst(4'h3, 4'h2, 1'b0);
        chk("mst c1", {busy, claimed, abort, stopped}, 4'h8);
        cyc(3);
        chk("mst c4", {busy, claimed, abort, stopped}, 4'hC);
        cyc(2);
        chk("mst c6", {busy, claimed, abort, stopped}, 4'h1);
        cyc(2);
    endtask
    task automatic t_claim_edge;
        start_mst(4'h5, 4'h3, 1'b0);
        cyc(4);
        chk("mst c5", {busy, claimed, abort, stopped}, 4'h8);
        cyc(1);
        chk("mst c6", {busy, claimed, abort, stopped}, 4'hC);
        cyc(3);
        chk("mst c9", {busy, claimed, abort, stopped}, 4'h1);
        cyc(2);
    endtask
    task automatic t_abort;
        start_mst(4'h0, 4'h0, 1'b0);
        cyc(4);
        chk("abort c5", {busy, claimed, abort, stopped}, 4'h8);
        cyc(1);
        chk("abort c6", {busy, claimed, abort, stopped}, 4'h2);
        cyc(1);
        chk("abort c7", {busy, claimed, abort, stopped}, 4'h0);
    endtask
    task automatic t_lock;
        start_mst(4'h2, 4'h1, 1'b1);
        chk("lock c1", {2'h0, dlo, dloe}, 4'h1);
        cyc(4);
        chk("lock held", {2'h0, dlo, dloe}, 4'h1);
        @(posedge clk);
        lock_done <= 1'b1;
        @(posedge clk);
        lock_done <= 1'b0;
        #1;
        chk("lock park", {2'h0, dlo, dloe}, 4'h3);
        cyc(1);
        chk("lock free", {2'h0, dlo, dloe}, 4'h2);
    endtask
    // Clock enable freezes a claimed transfer; last phase ends it, late stop ignored
    task automatic t_last_ce;
        start_mst(4'h1, 4'h4, 1'b0);
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        #1;
        chk("ce hold c3", {busy, claimed, abort, stopped}, 4'hC);
        @(posedge clk);
        ce <= 1'b1;
        last <= 1'b1;
        #1;
        chk("ce hold c4", {busy, claimed, abort, stopped}, 4'hC);
        @(posedge clk);
        last <= 1'b0;
        #1;
        chk("last c5", {busy, claimed, abort, stopped}, 4'h0);
        cyc(1);
        chk("idle stop c6", {busy, claimed, abort, stopped}, 4'h0);
        cyc(1);
    endtask
    // Lock kept over a following unlocked transfer, dropped by its abort
    task automatic t_lock_abort;
        start_mst(4'h1, 4'h1, 1'b1);
        chk("lk ab c1", {2'h0, dlo, dloe}, 4'h1);
        cyc(2);
        chk("lk ab c3", {busy, claimed, abort, stopped}, 4'h1);
        start_mst(4'h0, 4'h0, 1'b0);
        chk("lk keep", {2'h0, dlo, dloe}, 4'h1);
        cyc(5);
        chk("lk abort", {busy, claimed, abort, stopped}, 4'h2);
        chk("lk drop", {2'h0, dlo, dloe}, 4'h3);
        cyc(1);
        chk("lk free", {2'h0, dlo, dloe}, 4'h2);
    endtask
    // Bridge as target while an initiator holds lock
    task automatic t_target;
        drop_cnt = 0;
        up_oe = 0;
        @(posedge clk);
        tgt_claim <= 1'b1;
        lock_req <= 1'b1;
        @(posedge clk);
        tgt_claim <= 1'b0;
        #1;
        chk("tgt c1", {dco, dcoe, dso, dsoe}, 4'h7);
        @(posedge clk);
        tgt_stop <= 1'b1;
        @(posedge clk);
        tgt_stop <= 1'b0;
        #1;
        chk("tgt c3", {dco, dcoe, dso, dsoe}, 4'h5);
        @(posedge clk);
        tgt_end <= 1'b1;
        @(posedge clk);
        tgt_end <= 1'b0;
        lock_req <= 1'b0;
        #1;
        chk("tgt park", {dco, dcoe, dso, dsoe}, 4'hF);
        cyc(1);
        chk("tgt free", {dco, dcoe, dso, dsoe}, 4'hA);
        chk("up drop", {3'h0, drop_cnt != 0}, 4'h1);
        chk("up lock", {3'h0, up_oe != 0}, 4'h0);
    endtask
    task automatic end_of_test;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, well beyond the fewer than a hundred cycles needed
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_claim_stop();
        t_claim_edge();
        t_abort();
        t_lock();
        t_last_ce();
        t_lock_abort();
        t_target();
        end_of_test();
    end
endmodule

// ==== verilog/sbtl_pkg.sv ====
// Shared constants and types for the secondary bus termination and lock block
package sbtl_pkg;
    // Width of the claim-wait counter
    localparam int CNT_W = 3;
    // Cycles after frame assertion in which a target may still claim
    localparam logic [CNT_W-1:0] CLAIM_WAIT_CYC = 3'h5;
    // First count value inside the claim window
    localparam logic [CNT_W-1:0] CLAIM_CNT_FIRST = 3'h1;
    // Counter value after reset
    localparam logic [CNT_W-1:0] CLAIM_CNT_RST = 3'h0;
    // Level of an active-low pin when parked inactive
    localparam logic PIN_INACTIVE = 1'h1;
    // Output enable after reset (pin released)
    localparam logic OE_RST = 1'h0;
    // Master-side sequencing states
    typedef enum logic [1:0] {
        SBTL_IDLE,
        SBTL_WAIT,
        SBTL_DATA
    } sbtl_mst_e;
endpackage

// ==== verilog/sbtl_sts_drv.sv ====
// Sustained tri-state driver for one active-low shared control pin
`timescale 1ns/1ps
module sbtl_sts_drv (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    sbtl_sts_if.drv ctl
);
    logic pin_o_r;
    logic pin_o_nxt;
    logic pin_oe_r;
    logic pin_oe_nxt;

    // While owned drive the requested level; once released, park high one
    // cycle if the pin was last low, so the bus never floats from low.
    always_comb begin
        if (ctl.own) begin
            pin_oe_nxt = 1'h1;
            pin_o_nxt = ~ctl.act;
        end else begin
            pin_oe_nxt = pin_oe_r & ~pin_o_r; // [RL2]
            pin_o_nxt = sbtl_pkg::PIN_INACTIVE; // [RL4]
        end
    end

    // Pin registers, frozen while the clock enable is low
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pin_o_r <= sbtl_pkg::PIN_INACTIVE;
            pin_oe_r <= sbtl_pkg::OE_RST;
        end else if (i_ce) begin
            pin_o_r <= pin_o_nxt;
            pin_oe_r <= pin_oe_nxt;
        end
    end

    assign ctl.pin_o = pin_o_r;
    assign ctl.pin_oe = pin_oe_r;
endmodule

// ==== verilog/sbtl_sts_if.sv ====
// Control bundle between the block and one sustained tri-state pin driver
`timescale 1ns/1ps
interface sbtl_sts_if;
    logic own;
    logic act;
    logic pin_o;
    logic pin_oe;
    // Controller side requests ownership and the asserted level
    modport ctl (
        output own,
        output act,
        input pin_o,
        input pin_oe
    );
    // Driver side registers the pin and its enable
    modport drv (
        input own,
        input act,
        output pin_o,
        output pin_oe
    );
endinterface

// ==== verilog/sbtl_top.sv ====
// Secondary bus claim timeout, stop signalling and downstream lock control
//
// Overview of operation
// [RL1] As secondary master the bridge waits at most 5 cycles after frame for a claim, else master abort.
// [RL2] The target-claim pin is driven inactive for one cycle before it is released.
// [RL3] A target asks the initiator to stop with the stop pin, and the initiator obeys.
// [RL4] The stop pin is driven inactive for one cycle before it is released.
// [RL5] A downstream locked transaction asserts the lock pin one cycle after its first address phase.
// [RL6] Locked transactions are never forwarded upstream, only downstream.
// [RL7] A target asserts the target-claim pin low to show it accepts the transaction.
`timescale 1ns/1ps
module sbtl_top (
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    input wire logic I_CE,
    input wire logic I_MST_FRAME_START,
    input wire logic I_MST_LOCKED,
    input wire logic I_MST_LAST,
    input wire logic I_LOCK_DONE,
    input wire logic I_TGT_CLAIM,
    input wire logic I_TGT_STOP,
    input wire logic I_TGT_END,
    input wire logic I_SEC_TARGET_CLAIM_N_I,
    input wire logic I_SEC_STOP_N_I,
    input wire logic I_SEC_LOCK_N_I,
    output logic O_SEC_TARGET_CLAIM_N_O,
    output logic O_SEC_TARGET_CLAIM_N_OE,
    output logic O_SEC_STOP_N_O,
    output logic O_SEC_STOP_N_OE,
    output logic O_SEC_LOCK_N_O,
    output logic O_SEC_LOCK_N_OE,
    output logic O_MST_BUSY,
    output logic O_MST_CLAIMED,
    output logic O_MST_ABORT,
    output logic O_MST_STOPPED,
    output logic O_UP_LOCK_DROP
);
    sbtl_pkg::sbtl_mst_e st_r;
    sbtl_pkg::sbtl_mst_e st_nxt;
    logic [sbtl_pkg::CNT_W-1:0] cnt_r;
    logic [sbtl_pkg::CNT_W-1:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic claimed_r;
    logic claimed_nxt;
    logic abort_r;
    logic abort_nxt;
    logic stopped_r;
    logic stopped_nxt;
    logic lock_own_r;
    logic lock_own_nxt;
    logic tgt_act_r;
    logic tgt_act_nxt;
    logic tgt_stop_r;
    logic tgt_stop_nxt;
    logic drop_r;
    logic drop_nxt;
    logic lock_start;

    sbtl_sts_if claim_if ();
    sbtl_sts_if stop_if ();
    sbtl_sts_if lock_if ();

    // A locked transaction begins only from idle, on its address phase
    assign lock_start = I_MST_FRAME_START & I_MST_LOCKED & (st_r == sbtl_pkg::SBTL_IDLE);

    // Master sequencing: claim window, data, stop and abort
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        claimed_nxt = 1'h0;
        abort_nxt = 1'h0;
        stopped_nxt = 1'h0;
        case (st_r)
            sbtl_pkg::SBTL_IDLE: begin
                if (I_MST_FRAME_START) begin
                    st_nxt = sbtl_pkg::SBTL_WAIT;
                    cnt_nxt = sbtl_pkg::CLAIM_CNT_FIRST;
                end
            end
            sbtl_pkg::SBTL_WAIT: begin
                if (!I_SEC_TARGET_CLAIM_N_I) begin
                    st_nxt = sbtl_pkg::SBTL_DATA;
                    claimed_nxt = 1'h1;
                end else if (cnt_r == sbtl_pkg::CLAIM_WAIT_CYC) begin
                    st_nxt = sbtl_pkg::SBTL_IDLE; // [RL1]
                    abort_nxt = 1'h1; // [RL1]
                end else begin
                    cnt_nxt = cnt_r + sbtl_pkg::CLAIM_CNT_FIRST;
                end
            end
            sbtl_pkg::SBTL_DATA: begin
                // Stop from the target ends the transfer at once
                if (!I_SEC_STOP_N_I) begin
                    st_nxt = sbtl_pkg::SBTL_IDLE; // [RL3]
                    stopped_nxt = 1'h1; // [RL3]
                end else if (I_MST_LAST) begin
                    st_nxt = sbtl_pkg::SBTL_IDLE;
                end
            end
            default: begin
                st_nxt = sbtl_pkg::SBTL_IDLE;
            end
        endcase
        busy_nxt = (st_nxt != sbtl_pkg::SBTL_IDLE);
    end

    // Lock ownership; an abort drops the lock since nothing was claimed
    always_comb begin
        lock_own_nxt = lock_own_r;
        if (lock_start) begin
            lock_own_nxt = 1'h1; // [RL5]
        end else if (I_LOCK_DONE || abort_nxt) begin
            lock_own_nxt = 1'h0;
        end
    end

    // Target side: claim, stop request and upstream lock refusal
    always_comb begin
        tgt_act_nxt = tgt_act_r;
        tgt_stop_nxt = tgt_stop_r;
        if (I_TGT_END) begin
            tgt_act_nxt = 1'h0;
            tgt_stop_nxt = 1'h0;
        end else if (I_TGT_CLAIM || tgt_act_r) begin
            tgt_act_nxt = 1'h1; // [RL7]
            tgt_stop_nxt = tgt_stop_r | I_TGT_STOP; // [RL3]
        end
        // Lock seen while we are target is stripped, never passed up
        drop_nxt = tgt_act_r & ~I_SEC_LOCK_N_I & ~drop_r; // [RL6]
    end

    // Ownership fed straight through so the pin moves on the next edge
    assign claim_if.own = (tgt_act_r | I_TGT_CLAIM) & ~I_TGT_END;
    assign claim_if.act = claim_if.own; // [RL7]
    assign stop_if.own = claim_if.own;
    assign stop_if.act = stop_if.own & (tgt_stop_r | I_TGT_STOP); // [RL3]
    // Lock only ever driven as downstream initiator
    assign lock_if.own = lock_own_nxt; // [RL6]
    assign lock_if.act = lock_own_nxt; // [RL5]

    // State registers, all frozen while the clock enable is low
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN) begin
            st_r <= sbtl_pkg::SBTL_IDLE;
            cnt_r <= sbtl_pkg::CLAIM_CNT_RST;
            busy_r <= 1'h0;
            claimed_r <= 1'h0;
            abort_r <= 1'h0;
            stopped_r <= 1'h0;
            lock_own_r <= 1'h0;
            tgt_act_r <= 1'h0;
            tgt_stop_r <= 1'h0;
            drop_r <= 1'h0;
        end else if (I_CE) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            claimed_r <= claimed_nxt;
            abort_r <= abort_nxt;
            stopped_r <= stopped_nxt;
            lock_own_r <= lock_own_nxt;
            tgt_act_r <= tgt_act_nxt;
            tgt_stop_r <= tgt_stop_nxt;
            drop_r <= drop_nxt;
        end
    end

    // Pin drivers; each parks its pin high for a cycle before release
    sbtl_sts_drv u_claim_drv (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .ctl(claim_if.drv)
    );
    sbtl_sts_drv u_stop_drv (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .ctl(stop_if.drv)
    );
    sbtl_sts_drv u_lock_drv (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .ctl(lock_if.drv)
    );

    // Outputs, every one from a flip-flop
    assign O_SEC_TARGET_CLAIM_N_O = claim_if.pin_o;
    assign O_SEC_TARGET_CLAIM_N_OE = claim_if.pin_oe;
    assign O_SEC_STOP_N_O = stop_if.pin_o;
    assign O_SEC_STOP_N_OE = stop_if.pin_oe;
    assign O_SEC_LOCK_N_O = lock_if.pin_o;
    assign O_SEC_LOCK_N_OE = lock_if.pin_oe;
    assign O_MST_BUSY = busy_r;
    assign O_MST_CLAIMED = claimed_r;
    assign O_MST_ABORT = abort_r;
    assign O_MST_STOPPED = stopped_r;
    assign O_UP_LOCK_DROP = drop_r;

    // Checks; clock-enable gaps simply cancel an attempt in flight
    sequence s_frame_unclaimed;
        (I_MST_FRAME_START && st_r == sbtl_pkg::SBTL_IDLE) ##1 I_SEC_TARGET_CLAIM_N_I [*5];
    endsequence
    property p_abort_after_five;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN || !I_CE)
        s_frame_unclaimed |=> (O_MST_ABORT && !O_MST_BUSY);
    endproperty
    a_abort_after_five: assert property (p_abort_after_five) // [RL1]
        else $error("No master abort after five unclaimed cycles");
    property p_no_early_abort;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN || !I_CE)
        $rose(O_MST_ABORT) |-> $past(st_r == sbtl_pkg::SBTL_WAIT && cnt_r == sbtl_pkg::CLAIM_WAIT_CYC);
    endproperty
    a_no_early_abort: assert property (p_no_early_abort) // [RL1]
        else $error("Master abort before the claim window closed");
    property p_claim_park;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN || !I_CE)
        $fell(O_SEC_TARGET_CLAIM_N_OE) |-> $past(O_SEC_TARGET_CLAIM_N_O);
    endproperty
    a_claim_park: assert property (p_claim_park) // [RL2]
        else $error("Claim pin released without inactive cycle");
    property p_mst_stop;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN || !I_CE)
        (st_r == sbtl_pkg::SBTL_DATA && !I_SEC_STOP_N_I) |=> (O_MST_STOPPED && !O_MST_BUSY);
    endproperty
    a_mst_stop: assert property (p_mst_stop) // [RL3]
        else $error("Initiator ignored target stop");
    property p_stop_park;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN || !I_CE)
        $fell(O_SEC_STOP_N_OE) |-> $past(O_SEC_STOP_N_O);
    endproperty
    a_stop_park: assert property (p_stop_park) // [RL4]
        else $error("Stop pin released without inactive cycle");
    sequence s_lock_addr;
        lock_start && !lock_own_r;
    endsequence
    property p_lock_next;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN || !I_CE)
        s_lock_addr |-> (O_SEC_LOCK_N_O || !O_SEC_LOCK_N_OE)
            ##1 (O_SEC_LOCK_N_OE && !O_SEC_LOCK_N_O);
    endproperty
    a_lock_next: assert property (p_lock_next) // [RL5]
        else $error("Lock not asserted one cycle after address phase");
    property p_lock_down_only;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN || !I_CE)
        (O_SEC_LOCK_N_OE && !O_SEC_LOCK_N_O) |-> lock_own_r;
    endproperty
    a_lock_down_only: assert property (p_lock_down_only) // [RL6]
        else $error("Lock driven without a downstream locked transaction");
    property p_tgt_claim;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN || !I_CE)
        (I_TGT_CLAIM && !I_TGT_END) |=> (O_SEC_TARGET_CLAIM_N_OE && !O_SEC_TARGET_CLAIM_N_O);
    endproperty
    a_tgt_claim: assert property (p_tgt_claim) // [RL7]
        else $error("Claim pin not asserted after target claim");
endmodule
